/* File: hw/amt_pkg.sv */
package amt_pkg;
  // ----------------------------------------------------------------
  // memory kinds and timing defaults
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {AMT_SRAM, AMT_FLASH, AMT_PAGE_FLASH, AMT_PSRAM} amt_mem_kind_t;

  localparam int AMT_READ_SELECT_TO_VALID_PS = 15000;
  localparam int AMT_READ_ADDR_TO_VALID_PS = 15000;
  localparam int AMT_PAGE_ACCESS_PS = 25000;
  localparam int AMT_SELECT_HIGH_TO_HIZ_PS = 7000;
  localparam int AMT_OUTPUT_HIGH_TO_HIZ_PS = 7000;
  localparam int AMT_WRITE_CYCLE_PS = 15000;
  localparam int AMT_WRITE_PULSE_PS = 12000;
  localparam int AMT_WRITE_PHASE_PS = 12000;
  localparam int AMT_WRITE_HIGH_TO_LOWZ_PS = 0;
  localparam int AMT_WRITE_RECOVERY_PS = 27000;
  localparam int AMT_BUS_CLOCK_PERIOD_PS = 10000;
  localparam int AMT_ACLK_PERIOD_PS = 40000;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] AMT_ADDR_CTRL = 8'h00;
  localparam logic [7:0] AMT_ADDR_ADDR = 8'h04;
  localparam logic [7:0] AMT_ADDR_WDATA = 8'h08;
  localparam logic [7:0] AMT_ADDR_RDATA = 8'h0c;
  localparam logic [7:0] AMT_ADDR_STATUS = 8'h10;
  localparam int AMT_CTRL_LAST_BIT = 0;
  localparam int AMT_CTRL_READ_BIT = 1;
  localparam int AMT_CTRL_PAGE_BIT = 2;
  localparam int AMT_STAT_BUSY_BIT = 0;
  localparam int AMT_STAT_RVALID_BIT = 1;
  localparam int AMT_STAT_FULL_BIT = 2;
  localparam int AMT_STAT_EMPTY_BIT = 3;
  localparam logic [1:0] AMT_RESP_OKAY = 2'b00;
  localparam logic [1:0] AMT_RESP_SLVERR = 2'b10;
  localparam int AMT_FIFO_DEPTH = 4;

  // one memory request as it waits in the fifo
  typedef struct packed {
    logic read;
    logic last;
    logic page;
    logic [23:0] addr;
    logic [15:0] data;
  } amt_req_t;
endpackage

/* File: hw/amt_fifo.sv */
`timescale 1ns/1ps
module amt_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, low
  input wire logic [WIDTH-1:0] in_data, // fill side data
  input wire logic in_valid, // fill side valid
  output logic in_ready, // not full
  output logic [WIDTH-1:0] out_data, // drain side data
  output logic out_valid, // not empty
  input wire logic out_ready // drain side ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("amt_fifo depth must be power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic push;
  logic pop;

  // ----------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------
  assign in_ready = (wr_ptr_reg - rd_ptr_reg) != (AW + 1)'(DEPTH);
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_reg[AW-1:0]];

  // storage
  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  // pointers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule // amt_fifo

/* File: hw/amt_ctrl.sv */
`timescale 1ns/1ps
// Operation
// - wait select-to-valid before read data, async only
// - wait address-to-valid before sampling read data
// - page access time for page-mode flash reads
// - select-high to high-z gap after reads
// - output-high to high-z gap after reads
// - hold chip select low for write cycle
// - hold write enable low for pulse width
// - write phase sets idle cycles between writes
// - zero phase still gives one idle cycle
// - write-high to low-z gap before read
// - recovery idle cycles after burst last write, none for sram
// - counters scaled by bus clock period parameter
module amt_ctrl import amt_pkg::*; #(
  parameter amt_mem_kind_t MEM_KIND = AMT_FLASH,
  parameter int ADDR_W = 24,
  parameter int DATA_W = 16,
  parameter int FIFO_DEPTH = amt_pkg::AMT_FIFO_DEPTH,
  parameter int BUS_CLOCK_PERIOD_PS = amt_pkg::AMT_BUS_CLOCK_PERIOD_PS,
  parameter int READ_SELECT_TO_VALID_PS = amt_pkg::AMT_READ_SELECT_TO_VALID_PS,
  parameter int READ_ADDR_TO_VALID_PS = amt_pkg::AMT_READ_ADDR_TO_VALID_PS,
  parameter int PAGE_ACCESS_PS = amt_pkg::AMT_PAGE_ACCESS_PS,
  parameter int SELECT_HIGH_TO_HIZ_PS = amt_pkg::AMT_SELECT_HIGH_TO_HIZ_PS,
  parameter int OUTPUT_HIGH_TO_HIZ_PS = amt_pkg::AMT_OUTPUT_HIGH_TO_HIZ_PS,
  parameter int WRITE_CYCLE_PS = amt_pkg::AMT_WRITE_CYCLE_PS,
  parameter int WRITE_PULSE_PS = amt_pkg::AMT_WRITE_PULSE_PS,
  parameter int WRITE_PHASE_PS = amt_pkg::AMT_WRITE_PHASE_PS,
  parameter int WRITE_HIGH_TO_LOWZ_PS = amt_pkg::AMT_WRITE_HIGH_TO_LOWZ_PS,
  parameter int WRITE_RECOVERY_PS = amt_pkg::AMT_WRITE_RECOVERY_PS
) (
  input wire logic aclk, // clock, one period is BUS_CLOCK_PERIOD_PS
  input wire logic aresetn, // sync reset, low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic mem_chip_select_n, // memory chip select, low
  output logic mem_write_n, // memory write enable, low
  output logic mem_output_n, // memory output enable, low
  output logic [ADDR_W-1:0] mem_addr, // memory address
  output logic [DATA_W-1:0] mem_dq_o, // data to memory
  output logic mem_dq_oe_n, // data drive enable, low drives
  input wire logic [DATA_W-1:0] mem_dq_i // data from memory
);
  // ----------------------------------------------------------------
  // cycle counts, rounded up, fixed at elaboration
  // ----------------------------------------------------------------
  function automatic int cyc(input int ps);
    return (ps + BUS_CLOCK_PERIOD_PS - 1) / BUS_CLOCK_PERIOD_PS;
  endfunction
  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction
  // only asynchronous memory kinds are served by this engine
  localparam bit IS_ASYNC = 1'b1;
  localparam int RD_CYC = max2(1, max2(cyc(READ_SELECT_TO_VALID_PS),
    cyc(READ_ADDR_TO_VALID_PS)));
  localparam int PG_CYC = max2(1, cyc(PAGE_ACCESS_PS));
  localparam int HZ_CYC = max2(cyc(SELECT_HIGH_TO_HIZ_PS),
    cyc(OUTPUT_HIGH_TO_HIZ_PS));
  localparam int WP_CYC = max2(1, cyc(WRITE_PULSE_PS));
  localparam int WC_CYC = max2(WP_CYC, cyc(WRITE_CYCLE_PS));
  localparam int PH_CYC = max2(1, cyc(WRITE_PHASE_PS));
  localparam int LZ_CYC = cyc(WRITE_HIGH_TO_LOWZ_PS);
  localparam int REC_CYC = (MEM_KIND == AMT_SRAM) ? 0 : cyc(WRITE_RECOVERY_PS);
  localparam int CNT_W = 16;

  // refuse parameter sets that the carrier cannot serve or whose read, write, page or recovery counts overflow the counters
  initial begin
    if (BUS_CLOCK_PERIOD_PS <= 0) $error("bus clock period must be positive");
    if (ADDR_W < 4 || DATA_W < 1) $error("address too narrow for page compare");
    if (ADDR_W > 24 || DATA_W > 16) $error("address or data too wide for carrier");
    if (MEM_KIND != AMT_PAGE_FLASH && PAGE_ACCESS_PS != AMT_PAGE_ACCESS_PS)
      $error("page access time only for page-mode flash");
    if (max2(max2(RD_CYC, WC_CYC), max2(REC_CYC, PG_CYC)) >= 65536) $error("count too large");
    if (!IS_ASYNC) $error("async memory only");
  end

  // ----------------------------------------------------------------
  // sequencer state and held request
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_WRITE, ST_WGAP, ST_READ, ST_RHIZ} amt_state_t;

  amt_state_t state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] gap_reg;
  logic last_rd_page_reg;
  logic [ADDR_W-1:0] last_rd_addr_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic rdata_valid_reg;
  logic ctrl_last_reg;
  logic ctrl_page_reg;
  logic [23:0] addr_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  amt_req_t push_req;
  logic push_valid;
  logic push_ready;
  amt_req_t pop_req;
  logic pop_valid;
  logic pop_ready;
  logic wr_fire;
  logic in_page;

  // ----------------------------------------------------------------
  // request fifo
  // ----------------------------------------------------------------
  amt_fifo #(.WIDTH($bits(amt_req_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_data(push_req),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .out_data(pop_req),
    .out_valid(pop_valid),
    .out_ready(pop_ready)
  );

  // ----------------------------------------------------------------
  // axi4-lite write side
  // ----------------------------------------------------------------
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  // writes to wdata wait for fifo room, so back-pressure reaches the master
  assign push_valid = wr_fire && awaddr_reg == AMT_ADDR_WDATA;
  // request word built from the held write
  always_comb begin
    push_req = '0;
    push_req.read = wdata_reg[31];
    push_req.last = ctrl_last_reg;
    push_req.page = ctrl_page_reg;
    push_req.addr = addr_reg;
    push_req.data = wdata_reg[15:0];
    if (ctrl_page_reg == 1'b0) push_req.page = 1'b0;
  end

  // address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready;
      s_axi_wready <= !w_held_reg && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire && (!push_valid || push_ready)) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
      end
    end
  end

  // control and address registers, response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_last_reg <= 1'b1;
      ctrl_page_reg <= 1'b0;
      addr_reg <= 24'h000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AMT_RESP_OKAY;
    end else begin
      if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      if (wr_fire && (!push_valid || push_ready)) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= AMT_RESP_OKAY;
        unique case (awaddr_reg)
          AMT_ADDR_CTRL: begin
            if (wstrb_reg[0]) begin
              ctrl_last_reg <= wdata_reg[AMT_CTRL_LAST_BIT];
              ctrl_page_reg <= wdata_reg[AMT_CTRL_PAGE_BIT] && MEM_KIND == AMT_PAGE_FLASH;
            end
          end
          AMT_ADDR_ADDR: begin
            if (wstrb_reg[0]) addr_reg[7:0] <= wdata_reg[7:0];
            if (wstrb_reg[1]) addr_reg[15:8] <= wdata_reg[15:8];
            if (wstrb_reg[2]) addr_reg[23:16] <= wdata_reg[23:16];
          end
          AMT_ADDR_WDATA: addr_reg <= addr_reg + 24'h000001;
          default: s_axi_bresp <= AMT_RESP_SLVERR;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read side
  // ----------------------------------------------------------------
  // address decode, answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= AMT_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !s_axi_arvalid ? 1'b1 : 1'b0;
      if (!s_axi_rvalid && !s_axi_arready) s_axi_arready <= 1'b1;
      if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= AMT_RESP_OKAY;
        s_axi_rdata <= 32'h00000000;
        unique case (s_axi_araddr)
          AMT_ADDR_CTRL: begin
            s_axi_rdata[AMT_CTRL_LAST_BIT] <= ctrl_last_reg;
            s_axi_rdata[AMT_CTRL_PAGE_BIT] <= ctrl_page_reg;
          end
          AMT_ADDR_ADDR: s_axi_rdata[23:0] <= addr_reg;
          AMT_ADDR_RDATA: s_axi_rdata[DATA_W-1:0] <= rdata_reg;
          AMT_ADDR_STATUS: begin
            s_axi_rdata[AMT_STAT_BUSY_BIT] <= state_reg != ST_IDLE || pop_valid;
            s_axi_rdata[AMT_STAT_RVALID_BIT] <= rdata_valid_reg;
            s_axi_rdata[AMT_STAT_FULL_BIT] <= !push_ready;
            s_axi_rdata[AMT_STAT_EMPTY_BIT] <= !pop_valid;
          end
          default: s_axi_rresp <= AMT_RESP_SLVERR;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // memory timing engine
  // ----------------------------------------------------------------
  // fifo is drained only when idle and the gap has run out
  assign pop_ready = state_reg == ST_IDLE && gap_reg == '0;
  assign in_page = pop_req.page && last_rd_page_reg &&
    pop_req.addr[ADDR_W-1:3] == last_rd_addr_reg[ADDR_W-1:3];

  // read-result flag; a finishing read wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_valid_reg <= 1'b0;
    end else if (state_reg == ST_READ && cnt_reg == CNT_W'(1)) begin
      rdata_valid_reg <= 1'b1;
    end else if (s_axi_arvalid && s_axi_arready && s_axi_araddr == AMT_ADDR_RDATA) begin
      rdata_valid_reg <= 1'b0;
    end
  end

  // access sequencer: select, strobes and idle gaps
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      gap_reg <= '0;
      mem_chip_select_n <= 1'b1;
      mem_write_n <= 1'b1;
      mem_output_n <= 1'b1;
      mem_dq_oe_n <= 1'b1;
      mem_addr <= '0;
      mem_dq_o <= '0;
      rdata_reg <= '0;
      last_rd_page_reg <= 1'b0;
      last_rd_addr_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (gap_reg != '0) begin
            gap_reg <= gap_reg - 1'b1; // idle cycles between accesses
          end else if (pop_valid) begin
            mem_addr <= pop_req.addr[ADDR_W-1:0];
            mem_chip_select_n <= 1'b0;
            if (pop_req.read) begin
              mem_output_n <= 1'b0;
              mem_dq_oe_n <= 1'b1;
              cnt_reg <= in_page ? CNT_W'(PG_CYC) : CNT_W'(RD_CYC);
              last_rd_addr_reg <= pop_req.addr[ADDR_W-1:0];
              last_rd_page_reg <= pop_req.page;
              state_reg <= ST_READ;
            end else begin
              mem_write_n <= 1'b0;
              mem_dq_oe_n <= 1'b0;
              mem_dq_o <= pop_req.data[DATA_W-1:0];
              cnt_reg <= CNT_W'(WC_CYC);
              last_rd_page_reg <= 1'b0;
              gap_reg <= pop_req.last ? CNT_W'(max2(max2(PH_CYC, LZ_CYC), REC_CYC))
                                      : CNT_W'(max2(PH_CYC, LZ_CYC));
              state_reg <= ST_WRITE;
            end
          end
        end
        ST_WRITE: begin
          cnt_reg <= cnt_reg - 1'b1;
          if (cnt_reg == CNT_W'(WC_CYC - WP_CYC + 1)) mem_write_n <= 1'b1;
          if (cnt_reg == CNT_W'(1)) begin
            mem_chip_select_n <= 1'b1;
            mem_write_n <= 1'b1;
            mem_dq_oe_n <= 1'b1;
            gap_reg <= gap_reg - 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        ST_READ: begin
          cnt_reg <= cnt_reg - 1'b1;
          if (cnt_reg == CNT_W'(1)) begin
            rdata_reg <= mem_dq_i; // sample after access time
            mem_chip_select_n <= 1'b1;
            mem_output_n <= 1'b1;
            gap_reg <= CNT_W'(HZ_CYC);
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule // amt_ctrl

/* File: verification/amt_ctrl_assertions.sv */
`timescale 1ns/1ps
module amt_ctrl_chk #(
  parameter int BUS_CLOCK_PERIOD_PS = 40000,
  parameter int READ_SELECT_TO_VALID_PS = 15000,
  parameter int READ_ADDR_TO_VALID_PS = 15000,
  parameter int SELECT_HIGH_TO_HIZ_PS = 7000,
  parameter int OUTPUT_HIGH_TO_HIZ_PS = 7000,
  parameter int WRITE_CYCLE_PS = 15000,
  parameter int WRITE_PULSE_PS = 12000,
  parameter int WRITE_PHASE_PS = 12000,
  parameter int WRITE_HIGH_TO_LOWZ_PS = 0
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, low
  input wire logic mem_chip_select_n, // select, low
  input wire logic mem_write_n, // write enable, low
  input wire logic mem_output_n, // output enable, low
  input wire logic mem_dq_oe_n // data drive, low
);
  localparam int P = BUS_CLOCK_PERIOD_PS;
  localparam int WC = (WRITE_CYCLE_PS + P - 1) / P;
  localparam int WP = (WRITE_PULSE_PS + P - 1) / P;
  localparam int PH = (WRITE_PHASE_PS + P - 1) / P;
  localparam int LZ = (WRITE_HIGH_TO_LOWZ_PS + P - 1) / P;
  localparam int GAP = (PH > LZ) ? PH : ((LZ > 0) ? LZ : 1);
  localparam int RS = (READ_SELECT_TO_VALID_PS + P - 1) / P;
  localparam int RA = (READ_ADDR_TO_VALID_PS + P - 1) / P;
  localparam int RD = (RS > RA) ? RS : RA;
  localparam int CE = (SELECT_HIGH_TO_HIZ_PS + P - 1) / P;
  localparam int OE = (OUTPUT_HIGH_TO_HIZ_PS + P - 1) / P;
  localparam int HZ = (CE > OE) ? CE : OE;
  int low_cnt;
  int high_cnt;
  int we_cnt;
  logic wr_run;
  logic rd_run;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // run lengths of select low, select high, write enable low
  always_ff @(posedge aclk) begin
    if (!aresetn || mem_chip_select_n) low_cnt <= 0;
    else low_cnt <= low_cnt + 1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || !mem_chip_select_n) high_cnt <= 0;
    else high_cnt <= high_cnt + 1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || mem_write_n) we_cnt <= 0;
    else we_cnt <= we_cnt + 1;
  end
  // kind of the current or latest select run
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_run <= 1'b0;
      rd_run <= 1'b0;
    end else if (!mem_chip_select_n) begin
      wr_run <= !mem_write_n || (low_cnt != 0 && wr_run);
      rd_run <= !mem_output_n || (low_cnt != 0 && rd_run);
    end
  end
  a_write_select_len: assert property ($rose(mem_chip_select_n) && wr_run |-> low_cnt == WC)
    else $error("write select time wrong");
  a_write_pulse_len: assert property ($rose(mem_write_n) |-> we_cnt == WP)
    else $error("write pulse time wrong");
  a_write_gap_min: assert property ($fell(mem_chip_select_n) && wr_run |-> high_cnt >= GAP)
    else $error("idle gap after write too short");
  a_read_access_len: assert property ($rose(mem_chip_select_n) && rd_run |-> low_cnt >= RD)
    else $error("read access too short");
  a_read_hiz_gap: assert property ($fell(mem_chip_select_n) && rd_run |-> high_cnt >= HZ)
    else $error("bus reused too soon after read");
  a_output_in_select: assert property (!mem_output_n |-> !mem_chip_select_n)
    else $error("output enable outside select");
  a_no_bus_fight: assert property (!mem_dq_oe_n |-> mem_output_n)
    else $error("data driven during read");
  a_write_drives_bus: assert property (!mem_write_n |-> !mem_dq_oe_n && !mem_chip_select_n)
    else $error("write without select or data");
  a_idle_after_reset: assert property ($rose(aresetn) |-> mem_chip_select_n && mem_write_n)
    else $error("memory not idle after reset");
  c_write: cover property ($rose(mem_chip_select_n) && wr_run);
  c_read: cover property ($rose(mem_chip_select_n) && rd_run);
  c_tight_gap: cover property ($fell(mem_chip_select_n) && wr_run && high_cnt == 1);
endmodule // amt_ctrl_chk

bind amt_ctrl amt_ctrl_chk #(.BUS_CLOCK_PERIOD_PS(BUS_CLOCK_PERIOD_PS),
  .READ_SELECT_TO_VALID_PS(READ_SELECT_TO_VALID_PS), .READ_ADDR_TO_VALID_PS(READ_ADDR_TO_VALID_PS),
  .SELECT_HIGH_TO_HIZ_PS(SELECT_HIGH_TO_HIZ_PS), .OUTPUT_HIGH_TO_HIZ_PS(OUTPUT_HIGH_TO_HIZ_PS),
  .WRITE_CYCLE_PS(WRITE_CYCLE_PS), .WRITE_PULSE_PS(WRITE_PULSE_PS),
  .WRITE_PHASE_PS(WRITE_PHASE_PS), .WRITE_HIGH_TO_LOWZ_PS(WRITE_HIGH_TO_LOWZ_PS))
  i_amt_ctrl_chk (.aclk(aclk), .aresetn(aresetn), .mem_chip_select_n(mem_chip_select_n),
  .mem_write_n(mem_write_n), .mem_output_n(mem_output_n), .mem_dq_oe_n(mem_dq_oe_n));

/* File: verification/amt_flash_model.sv */
`timescale 1ns/1ps
module amt_flash_model #(
  parameter int ACCESS_NS = 96, // read access time
  parameter int PERIOD_NS = 40 // bus clock period
) (
  input wire logic aclk, // bus clock, write capture
  input wire logic mem_chip_select_n, // select, low
  input wire logic mem_write_n, // write enable, low
  input wire logic mem_output_n, // output enable, low
  input wire logic [23:0] mem_addr, // address
  input wire logic [15:0] mem_dq_o, // data from controller
  input wire logic mem_dq_oe_n, // controller drives when low
  output logic [15:0] mem_dq_i, // resolved data line
  output int gap_cyc // idle cycles before latest select
);
  logic [15:0] cells [32];
  logic [15:0] own_dq = 16'h5a5a;
  logic [15:0] wr_buf;
  time t_sel = 0;
  time t_rise = 0;
  // access timing restarts on select or address change
  always @(negedge mem_chip_select_n or mem_addr) t_sel = $time;
  // idle gap length seen before each select
  always @(negedge mem_chip_select_n) gap_cyc = int'(($time - t_rise) / PERIOD_NS);
  always @(posedge mem_chip_select_n) t_rise = $time;
  // data latched mid-cycle, stored when write enable rises
  always @(negedge aclk) if (!mem_chip_select_n && !mem_write_n) wr_buf = mem_dq_o;
  always @(posedge mem_write_n) if (!mem_chip_select_n) cells[mem_addr[4:0]] = wr_buf;
  // valid only after access time, else a changing pattern
  always #1 begin
    if (!mem_chip_select_n && !mem_output_n && $time - t_sel >= ACCESS_NS) begin
      own_dq = cells[mem_addr[4:0]];
    end else begin
      own_dq = ~own_dq;
    end
  end
  assign mem_dq_i = mem_dq_oe_n ? own_dq : mem_dq_o;
endmodule // amt_flash_model

/* File: verification/test_amt_ctrl.sv */
`timescale 1ns/1ps
module test_amt_ctrl;
  import amt_pkg::*;
  localparam int P_PS = 40000;
  localparam int FLASH_ACC_PS = 96000;
  localparam int FLASH_REC_PS = 200000;
  localparam int REC_CYC = (FLASH_REC_PS + P_PS - 1) / P_PS;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awaddr = 0;
  logic [7:0] araddr = 0;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 0;
  logic wvalid = 0;
  logic arvalid = 0;
  logic bready = 1;
  logic rready = 1;
  logic [1:0] bresp, rresp;
  logic bvalid, rvalid, awready, wready, arready, cs_n, we_n, oe_n, dq_oe_n;
  logic [31:0] rdata, v;
  logic [23:0] maddr;
  logic [15:0] dq_o, dq_i;
  logic [1:0] bq[$];
  logic [34:0] rq[$];
  logic [34:0] re;
  logic [15:0] d[8];
  int gap_cyc;
  int error_cnt = 0;
  int checks_done = 0;
  always #20 aclk = ~aclk;
  amt_ctrl #(.BUS_CLOCK_PERIOD_PS(P_PS), .READ_SELECT_TO_VALID_PS(FLASH_ACC_PS),
    .READ_ADDR_TO_VALID_PS(FLASH_ACC_PS), .WRITE_CYCLE_PS(120000), .WRITE_PULSE_PS(80000),
    .WRITE_PHASE_PS(0), .WRITE_RECOVERY_PS(FLASH_REC_PS)) i_amt_ctrl (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .mem_chip_select_n(cs_n), .mem_write_n(we_n), .mem_output_n(oe_n), .mem_addr(maddr),
    .mem_dq_o(dq_o), .mem_dq_oe_n(dq_oe_n), .mem_dq_i(dq_i));
  amt_flash_model i_amt_flash_model (.aclk(aclk), .mem_chip_select_n(cs_n),
    .mem_write_n(we_n), .mem_output_n(oe_n), .mem_addr(maddr), .mem_dq_o(dq_o),
    .mem_dq_oe_n(dq_oe_n), .mem_dq_i(dq_i), .gap_cyc(gap_cyc));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic expire(input int n);
    if (n >= 400) begin
      error_cnt++;
      $display("CHECK FAILED wait expected answer seen none");
      print_verdict();
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] dat, input logic [1:0] er);
    int n;
    bq.push_back(er);
    awaddr <= a;
    wdata <= dat;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 400; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    expire(n);
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er,
                     input logic cmp);
    int n;
    rq.push_back({cmp, er, ed});
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 400; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    v = rdata;
    expire(n);
  endtask
  task automatic poll(input int bitn, input logic want);
    int n;
    for (n = 0; n < 400; n++) begin
      axr(AMT_ADDR_STATUS, 32'h0, AMT_RESP_OKAY, 1'b0);
      if (v[bitn] === want) break;
    end
    expire(n);
  endtask
  // answers compared against the oldest note
  always @(posedge aclk) begin
    if (bvalid && bready) chk("bresp", {30'h0, bresp}, {30'h0, bq.pop_front()});
    if (rvalid && rready) begin
      re = rq.pop_front();
      chk("rresp", {30'h0, rresp}, {30'h0, re[33:32]});
      if (re[34]) chk("rdata", rdata, re[31:0]);
    end
  end
  initial begin
    void'($urandom(32'hf3cee514));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axr(AMT_ADDR_STATUS, 32'h8, AMT_RESP_OKAY, 1'b1);
    axr(AMT_ADDR_CTRL, 32'h1, AMT_RESP_OKAY, 1'b1);
    axr(8'h40, 32'h0, AMT_RESP_SLVERR, 1'b0);
    axw(8'h40, 32'h0, AMT_RESP_SLVERR);
    wstrb <= 4'h2;
    axw(AMT_ADDR_ADDR, 32'h00c3a5f0, AMT_RESP_OKAY);
    wstrb <= 4'hf;
    axr(AMT_ADDR_ADDR, 32'h0000a500, AMT_RESP_OKAY, 1'b1);
    $display("test reset done");
    axw(AMT_ADDR_CTRL, 32'h0, AMT_RESP_OKAY);
    axw(AMT_ADDR_ADDR, 32'h0, AMT_RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      d[i] = 16'($urandom);
      axw(AMT_ADDR_WDATA, {16'h0, d[i]}, AMT_RESP_OKAY);
    end
    poll(AMT_STAT_EMPTY_BIT, 1'b1);
    chk("gap", gap_cyc, 32'd1);
    $display("test flood done");
    axw(AMT_ADDR_ADDR, 32'h0, AMT_RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      axw(AMT_ADDR_WDATA, 32'h8000_0000, AMT_RESP_OKAY);
      poll(AMT_STAT_RVALID_BIT, 1'b1);
      axr(AMT_ADDR_RDATA, {16'h0, d[i]}, AMT_RESP_OKAY, 1'b1);
    end
    axr(AMT_ADDR_STATUS, 32'h8, AMT_RESP_OKAY, 1'b1);
    $display("test readback done");
    axw(AMT_ADDR_CTRL, 32'h1, AMT_RESP_OKAY);
    axw(AMT_ADDR_WDATA, {16'h0, 16'($urandom)}, AMT_RESP_OKAY);
    axw(AMT_ADDR_WDATA, {16'h0, 16'($urandom)}, AMT_RESP_OKAY);
    poll(AMT_STAT_BUSY_BIT, 1'b0);
    chk("recovery", {31'h0, gap_cyc >= REC_CYC}, 32'h1);
    $display("test recovery done");
    print_verdict();
  end
endmodule // test_amt_ctrl
